// ===== design/wdrom_mem.sv
`timescale 1ns/10ps
`default_nettype none

module wdrom_mem (
    input  wire logic        clk,
    wdrom_mem_if.store       port
);

    logic [7:0] cells [wdrom_pkg::MEM_DEPTH];

    // No reset on the array: contents are only trusted after a fill
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            cells[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge clk) begin
        port.rd_data <= cells[port.rd_addr];
    end

endmodule : wdrom_mem

`default_nettype wire

// ===== design/wdrom_top.sv
// Behaviour
// - Configuration attributes byte always has bit 7 set to one.
// - Configuration attributes bits 3 to 0 are always zero.
// - Attributes: bit 6 self-powered, bit 5 remote wakeup, bit 4 battery.
// - Self-powered attribute bit is always one.
// - Remote wakeup bit set exactly when the configuration supports wakeup.
// - Maximum power byte at configuration offset 8 is always zero.
// - Wired configuration never carries the wireless endpoint descriptor.
// - Endpoint address: number in 3:0, zeros in 6:4, direction in 7; on a control endpoint bit 7 reads as zero.
// - Endpoint descriptor byte 0 holds its size in bytes.
// - An endpoint companion descriptor follows the endpoint descriptor.
// - Transfer type in attribute bits 1:0: control, iso, bulk, interrupt.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module wdrom_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    logic                     rst_meta_n;
    logic                     rst_sync_n;

    logic                     ctrl_wake;
    logic                     ctrl_batt;
    logic                     ctrl_wired;
    logic [23:0]              cfg;
    logic [31:0]              ep;
    logic [4:0]               ptr;

    logic                     dp_write;
    logic [7:0]               dp_addr;
    logic [1:0]               rd_wait;

    wdrom_pkg::wdrom_fill_t   fill_state;
    logic [4:0]               fill_idx;
    logic [4:0]               img_len;
    logic                     img_valid;
    logic                     fill_wired;
    logic                     build_req;

    logic                     accept;
    logic                     wr_ok;
    logic [4:0]               next_len;

    wdrom_mem_if              mem_bus ();

    // Reset: asynchronous assertion, release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    function automatic logic [7:0] attr_byte(input logic wake, input logic batt);
        logic [7:0] a;
        a = 8'h00;
        a[wdrom_pkg::ATTR_ONE_BIT]  = 1'b1;
        a[wdrom_pkg::ATTR_SELF_BIT] = 1'b1;
        a[wdrom_pkg::ATTR_WAKE_BIT] = wake;
        a[wdrom_pkg::ATTR_BATT_BIT] = batt;
        return a;
    endfunction : attr_byte

    function automatic logic [7:0] ep_addr_byte(input logic [31:0] e);
        logic [7:0] a;
        a = 8'h00;
        a[3:0] = e[wdrom_pkg::EP_NUM_LSB +: 4];
        // Direction has no meaning on a control endpoint, so it reads as OUT there
        if (e[wdrom_pkg::EP_TYPE_LSB +: 2] != wdrom_pkg::XFER_CONTROL) begin
            a[7] = e[wdrom_pkg::EP_DIR_BIT];
        end
        return a;
    endfunction : ep_addr_byte

    function automatic logic [7:0] image_byte(
        input logic [4:0]  idx,
        input logic [4:0]  total,
        input logic        wake,
        input logic        batt,
        input logic [23:0] c,
        input logic [31:0] e
    );
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            5'h00: b = wdrom_pkg::CFG_LEN;
            5'h01: b = wdrom_pkg::DT_CONFIG;
            5'h02: b = {3'h0, total};
            5'h03: b = 8'h00;
            5'h04: b = c[wdrom_pkg::CFG_NIF_LSB +: 8];
            5'h05: b = c[wdrom_pkg::CFG_VAL_LSB +: 8];
            5'h06: b = c[wdrom_pkg::CFG_STR_LSB +: 8];
            5'h07: b = attr_byte(wake, batt);
            5'h08: b = 8'h00;
            5'h09: b = wdrom_pkg::EP_LEN;
            5'h0a: b = wdrom_pkg::DT_ENDPOINT;
            5'h0b: b = ep_addr_byte(e);
            5'h0c: b = {6'h00, e[wdrom_pkg::EP_TYPE_LSB +: 2]};
            5'h0d: b = e[wdrom_pkg::EP_MPS_LSB +: 8];
            5'h0e: b = e[wdrom_pkg::EP_MPS_LSB + 8 +: 8];
            5'h0f: b = e[wdrom_pkg::EP_IVL_LSB +: 8];
            5'h10: b = wdrom_pkg::COMP_LEN;
            5'h11: b = wdrom_pkg::DT_COMPANION;
            default: b = 8'h00;
        endcase
        return b;
    endfunction : image_byte

    // Bus decode
    assign accept = hsel & hready & htrans[wdrom_pkg::HTRANS_ACT_BIT];
    // Settings are frozen while the image is being filled
    assign wr_ok  = dp_write & (fill_state == wdrom_pkg::FILL_IDLE);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else if (accept) begin
            dp_write <= hwrite;
            dp_addr  <= haddr[7:0];
        end else if (hreadyout) begin
            dp_write <= 1'b0;
        end
    end

    // Control register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            {ctrl_wired, ctrl_batt, ctrl_wake} <= wdrom_pkg::CTRL_RST;
            build_req                          <= 1'b0;
        end else begin
            build_req <= 1'b0;
            if (wr_ok && dp_addr == wdrom_pkg::ADDR_CTRL) begin
                ctrl_wake  <= hwdata[wdrom_pkg::CTRL_WAKE_BIT];
                ctrl_batt  <= hwdata[wdrom_pkg::CTRL_BATT_BIT];
                ctrl_wired <= hwdata[wdrom_pkg::CTRL_WIRED_BIT];
                build_req  <= hwdata[wdrom_pkg::CTRL_BUILD_BIT];
            end
        end
    end

    // Configuration and endpoint settings
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg <= wdrom_pkg::CFG_RST;
            ep  <= wdrom_pkg::EP_RST;
        end else begin
            if (wr_ok && dp_addr == wdrom_pkg::ADDR_CFG) begin
                cfg <= hwdata[23:0];
            end
            if (wr_ok && dp_addr == wdrom_pkg::ADDR_EP) begin
                ep <= hwdata;
            end
        end
    end

    // Image length: a wired link gets the configuration descriptor alone
    assign next_len = ctrl_wired ? wdrom_pkg::IMG_WIRED_LEN
                                 : wdrom_pkg::IMG_FULL_LEN;

    // Image fill engine, one byte per cycle
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fill_state <= wdrom_pkg::FILL_IDLE;
            fill_idx   <= 5'h00;
            img_len    <= 5'h00;
            img_valid  <= 1'b0;
            fill_wired <= 1'b0;
        end else begin
            unique case (fill_state)
                wdrom_pkg::FILL_IDLE: begin
                    if (build_req) begin
                        fill_state <= wdrom_pkg::FILL_RUN;
                        fill_idx   <= 5'h00;
                        img_len    <= next_len;
                        fill_wired <= ctrl_wired;
                        img_valid  <= 1'b0;
                    end
                end
                wdrom_pkg::FILL_RUN: begin
                    if (fill_idx == img_len - 5'h01) begin
                        fill_state <= wdrom_pkg::FILL_IDLE;
                        img_valid  <= 1'b1;
                    end else begin
                        fill_idx <= fill_idx + 5'h01;
                    end
                end
                default: begin
                    fill_state <= wdrom_pkg::FILL_IDLE;
                end
            endcase
        end
    end

    assign mem_bus.wr_en   = (fill_state == wdrom_pkg::FILL_RUN) &
                             ~(fill_wired & (fill_idx >= wdrom_pkg::IMG_EP_BASE));
    assign mem_bus.wr_addr = fill_idx;
    assign mem_bus.wr_data = image_byte(fill_idx, img_len, ctrl_wake, ctrl_batt, cfg, ep);
    assign mem_bus.rd_addr = ptr;

    wdrom_mem u_mem (
        .clk  (clk),
        .port (mem_bus.store)
    );

    // Read pointer: software-set, advances after each byte read
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ptr <= wdrom_pkg::PTR_RST;
        end else if (rd_wait == 2'h1) begin
            ptr <= ptr + 5'h01;
        end else if (wr_ok && dp_addr == wdrom_pkg::ADDR_PTR) begin
            ptr <= hwdata[4:0];
        end
    end

    // Read data and wait states
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            rd_wait   <= 2'h0;
        end else if (rd_wait != 2'h0) begin
            rd_wait <= rd_wait - 2'h1;
            if (rd_wait == 2'h1) begin
                hrdata    <= {24'h000000, mem_bus.rd_data};
                hreadyout <= 1'b1;
            end
        end else if (accept && !hwrite) begin
            hrdata <= 32'h00000000;
            unique case (haddr[7:0])
                wdrom_pkg::ADDR_CTRL: begin
                    hrdata[wdrom_pkg::CTRL_WAKE_BIT]  <= ctrl_wake;
                    hrdata[wdrom_pkg::CTRL_BATT_BIT]  <= ctrl_batt;
                    hrdata[wdrom_pkg::CTRL_WIRED_BIT] <= ctrl_wired;
                end
                wdrom_pkg::ADDR_CFG: begin
                    hrdata <= {8'h00, cfg};
                end
                wdrom_pkg::ADDR_EP: begin
                    hrdata <= ep;
                end
                wdrom_pkg::ADDR_STATUS: begin
                    hrdata[wdrom_pkg::ST_BUSY_BIT]       <= fill_state == wdrom_pkg::FILL_RUN;
                    hrdata[wdrom_pkg::ST_VALID_BIT]      <= img_valid;
                    hrdata[wdrom_pkg::ST_LEN_LSB +: 5]   <= img_len;
                end
                wdrom_pkg::ADDR_PTR: begin
                    hrdata[4:0] <= ptr;
                end
                wdrom_pkg::ADDR_DATA: begin
                    // Store output lags the pointer, so hold the bus two cycles
                    rd_wait   <= wdrom_pkg::READ_WAIT;
                    hreadyout <= 1'b0;
                end
                default: begin
                    hrdata <= 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

endmodule : wdrom_top

`default_nettype wire

// ===== inc/wdrom_mem_if.sv
`timescale 1ns/10ps
`default_nettype none

interface wdrom_mem_if;
    logic       wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;

    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
    modport user  (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface : wdrom_mem_if

`default_nettype wire

// ===== inc/wdrom_pkg.sv
package wdrom_pkg;

    // Register byte addresses (low byte of haddr)
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_CFG        = 8'h04;
    localparam logic [7:0]  ADDR_EP         = 8'h08;
    localparam logic [7:0]  ADDR_STATUS     = 8'h0c;
    localparam logic [7:0]  ADDR_PTR        = 8'h10;
    localparam logic [7:0]  ADDR_DATA       = 8'h14;

    // Field positions
    localparam int          CTRL_WAKE_BIT   = 0;
    localparam int          CTRL_BATT_BIT   = 1;
    localparam int          CTRL_WIRED_BIT  = 2;
    localparam int          CTRL_BUILD_BIT  = 3;
    localparam int          CFG_NIF_LSB     = 0;
    localparam int          CFG_VAL_LSB     = 8;
    localparam int          CFG_STR_LSB     = 16;
    localparam int          EP_NUM_LSB      = 0;
    localparam int          EP_DIR_BIT      = 4;
    localparam int          EP_TYPE_LSB     = 5;
    localparam int          EP_IVL_LSB      = 8;
    localparam int          EP_MPS_LSB      = 16;
    localparam int          ST_BUSY_BIT     = 0;
    localparam int          ST_VALID_BIT    = 1;
    localparam int          ST_LEN_LSB      = 8;
    localparam int          ATTR_ONE_BIT    = 7;
    localparam int          ATTR_SELF_BIT   = 6;
    localparam int          ATTR_WAKE_BIT   = 5;
    localparam int          ATTR_BATT_BIT   = 4;
    localparam int          HTRANS_ACT_BIT  = 1;

    // Values after reset
    localparam logic [2:0]  CTRL_RST        = 3'h0;
    localparam logic [23:0] CFG_RST         = 24'h000101;
    localparam logic [31:0] EP_RST          = 32'h00400001;
    localparam logic [4:0]  PTR_RST         = 5'h00;

    // Descriptor layout
    localparam logic [7:0]  CFG_LEN         = 8'h09;
    localparam logic [7:0]  EP_LEN          = 8'h07;
    localparam logic [7:0]  COMP_LEN        = 8'h0a;
    localparam logic [7:0]  DT_CONFIG       = 8'h02;
    localparam logic [7:0]  DT_ENDPOINT     = 8'h05;
    localparam logic [7:0]  DT_COMPANION    = 8'h11;
    localparam logic [4:0]  IMG_EP_BASE     = 5'h09;
    localparam logic [4:0]  IMG_COMP_BASE   = 5'h10;
    localparam logic [4:0]  IMG_WIRED_LEN   = 5'h09;
    localparam logic [4:0]  IMG_FULL_LEN    = 5'h1a;

    // Byte store
    localparam int          MEM_AW          = 5;
    localparam int          MEM_DEPTH       = 32;

    // Wait states on a byte read, so the store output settles after a pointer write
    localparam logic [1:0]  READ_WAIT       = 2'h2;

    typedef enum logic [1:0] {
        XFER_CONTROL = 2'h0,
        XFER_ISO     = 2'h1,
        XFER_BULK    = 2'h2,
        XFER_INTR    = 2'h3
    } wdrom_xfer_t;

    typedef enum logic [1:0] {
        FILL_IDLE = 2'h1,
        FILL_RUN  = 2'h2
    } wdrom_fill_t;

endpackage : wdrom_pkg

// ===== verif/wdrom_host.sv
`timescale 1ns/10ps
`default_nettype none

module wdrom_host (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    task automatic wait_rdy(inout logic ok);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!hready && n < 50);
        ok = ok & hready;
    endtask : wait_rdy

    // Entered just after a rising edge; returns just after the data-phase edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
        ok = 1'b1;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy(ok);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        // A read leaves the write bus churning, never holding a stale word
        hwdata <= w ? wd : ~hwdata;
        wait_rdy(ok);
        rd = hrdata;
    endtask : xfer
endmodule : wdrom_host

`default_nettype wire

// ===== verif/wdrom_props.sv
`timescale 1ns/10ps
`default_nettype none

module wdrom_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata
);
    logic       take;
    logic       is_data;
    logic       pend;
    logic       ptr_wr;
    logic [4:0] ptr;
    logic       done;

    assign take    = hsel & hready & htrans[1];
    assign is_data = haddr[7:0] == wdrom_pkg::ADDR_DATA;
    assign done    = pend & hreadyout;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend   <= 1'b0;
            ptr_wr <= 1'b0;
        end else if (take) begin
            pend   <= !hwrite && is_data;
            ptr_wr <= hwrite && haddr[7:0] == wdrom_pkg::ADDR_PTR;
        end else if (hreadyout) begin
            pend   <= 1'b0;
            ptr_wr <= 1'b0;
        end
    end

    // Pointer mirror goes stale if the pointer is written during a build
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= 5'h00;
        end else if (ptr_wr && hreadyout) begin
            ptr <= hwdata[4:0];
        end else if (done) begin
            ptr <= ptr + 5'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    okay_resp_a : assert property (hresp == 1'b0)
        else $error("error response seen");
    data_wait_a : assert property (take && !hwrite && is_data |=> !hreadyout [*2] ##1 hreadyout)
        else $error("byte read wait count wrong");
    upper_zero_a : assert property (done |-> hrdata[31:8] == 24'h0)
        else $error("byte read upper bits set");
    attr_one_a : assert property (done && ptr == 5'h07 |-> hrdata[7])
        else $error("attribute top bit clear");
    attr_low_a : assert property (done && ptr == 5'h07 |-> hrdata[3:0] == 4'h0)
        else $error("attribute low bits set");
    self_pow_a : assert property (done && ptr == 5'h07 |-> hrdata[6])
        else $error("self powered bit clear");
    max_pow_a : assert property (done && ptr == 5'h08 |-> hrdata[7:0] == 8'h00)
        else $error("max power not zero");
    ep_addr_a : assert property (done && ptr == 5'h0b |-> hrdata[6:4] == 3'h0)
        else $error("endpoint address reserved bits set");
endmodule : wdrom_props

bind wdrom_top wdrom_props u_props (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

`default_nettype wire

// ===== verif/wireless_descriptor_rom_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module wireless_descriptor_rom_tb_top;
    logic             clk;
    logic             rst_n;
    wire logic        hsel;
    wire logic [31:0] haddr;
    wire logic [1:0]  htrans;
    wire logic        hwrite;
    wire logic [2:0]  hsize;
    wire logic [31:0] hwdata;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic [31:0] hrdata;
    int               n_fail;
    int               comparisons;
    logic [7:0]       ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
    logic [31:0]      rv [6] = '{32'h0, 32'h000101, 32'h00400001, 32'h0, 32'h0, 32'h0};

    wdrom_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    wdrom_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        $display("errors %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        logic ok;
        host.xfer(w, a, wd, d, ok);
        if (!ok) begin
            n_fail++;
            summarize();
        end
    endtask : acc

    // Image byte worked out from the settings: ctl = {build, wired, battery, wakeup}
    function automatic logic [7:0] exp_byte(input int k, input logic [3:0] ctl,
                                            input logic [23:0] cfg, input logic [31:0] ep);
        case (k)
            0: return 8'h09;
            1: return 8'h02;
            2: return ctl[2] ? 8'h09 : 8'h1a;
            4: return cfg[7:0];
            5: return cfg[15:8];
            6: return cfg[23:16];
            7: return {2'h3, ctl[0], ctl[1], 4'h0};
            9: return 8'h07;
            10: return 8'h05;
            11: return {ep[6:5] != 2'h0 && ep[4], 3'h0, ep[3:0]};
            12: return {6'h0, ep[6:5]};
            13: return ep[23:16];
            14: return ep[31:24];
            15: return ep[15:8];
            16: return 8'h0a;
            17: return 8'h11;
            default: return 8'h00;
        endcase
    endfunction : exp_byte

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        summarize();
    end

    initial begin
        logic [31:0] d;
        logic [23:0] cfg;
        logic [31:0] ep;
        logic [3:0]  ctl;
        int          n;
        int          len;
        rst_n = 1'b0;
        n_fail = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        acc(1'b1, 8'h20, 32'hffffffff, d);
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, ra[i], 32'h0, d);
            chk("reset value", d, rv[i]);
        end
        for (int i = 0; i < 8; i++) begin
            cfg = {8'(8'h30 + i), 8'(8'h20 + i), i == 7 ? 8'hff : 8'(i)};
            ep = {16'(16'h0200 + i), 8'(i + 1), 1'b0, 2'(i), !i[0], 4'(i == 7 ? 15 : i)};
            ctl = {1'b1, 3'(i)};
            acc(1'b1, 8'h04, {8'h0, cfg}, d);
            acc(1'b1, 8'h08, ep, d);
            acc(1'b1, 8'h00, {28'h0, ctl}, d);
            // Lands while the build is busy, so it must be dropped
            acc(1'b1, 8'h04, 32'h00ffffff, d);
            n = 0;
            do begin
                acc(1'b0, 8'h0c, 32'h0, d);
                n++;
            end while (d[0] !== 1'b0 && n < 100);
            // A build that never finishes is a failure, not a later mismatch
            if (d[0] !== 1'b0) begin
                n_fail++;
                summarize();
            end
            len = ctl[2] ? 9 : 26;
            chk("status", d, {19'h0, 5'(len), 8'h02});
            acc(1'b0, 8'h04, 32'h0, d);
            chk("cfg kept", d, {8'h0, cfg});
            acc(1'b0, 8'h00, 32'h0, d);
            chk("ctrl", d, {29'h0, ctl[2:0]});
            acc(1'b1, 8'h10, 32'h0, d);
            for (int k = 0; k < len; k++) begin
                acc(1'b0, 8'h14, 32'h0, d);
                chk("image byte", d, {24'h0, exp_byte(k, ctl, cfg, ep)});
            end
            acc(1'b0, 8'h10, 32'h0, d);
            chk("pointer", d, 32'(len));
        end
        summarize();
    end
endmodule : wireless_descriptor_rom_tb_top

`default_nettype wire
